/* lfoc_pkg.sv */
// Constants shared by the low-frequency oscillator control block.
package lfoc_pkg;
   // Register offsets.
   localparam logic [7:0] ICTL_OFF   = 8'h18;
   localparam logic [7:0] XCTL_OFF   = 8'h1C;
   localparam logic [7:0] STAT_OFF   = 8'h04;
   // Field positions.
   localparam int         RSB_BIT    = 7;
   localparam int         CRYSTAL_STARTUP_TIME_LSB   = 4;
   localparam int         CRYSTAL_STARTUP_TIME_MSB   = 5;
   localparam int         SEL_BIT    = 2;
   localparam int         LP_BIT     = 1;
   localparam int         EN_BIT     = 0;
   localparam int         XS_BIT     = 4;
   // Reset values.
   localparam logic [7:0] XCTL_RST   = 8'h00;
   localparam logic [7:0] ICTL_RST   = 8'h00;
   // Sleep mode encoding seen on the mode input.
   localparam logic [1:0] MODE_ACT   = 2'h0;
   localparam logic [1:0] MODE_IDLE  = 2'h1;
   localparam logic [1:0] MODE_STBY  = 2'h2;
   localparam logic [1:0] MODE_PDN   = 2'h3;
   // Crystal start-up time codes.
   localparam logic [1:0] CRYSTAL_STARTUP_TIME_1K    = 2'h0;
   localparam logic [1:0] CRYSTAL_STARTUP_TIME_16K   = 2'h1;
   localparam logic [1:0] CRYSTAL_STARTUP_TIME_32K   = 2'h2;
   localparam logic [1:0] CRYSTAL_STARTUP_TIME_64K   = 2'h3;
   // Oscillator cycle counts.
   localparam int         CNT_W      = 17;
   localparam logic [16:0] CYC_1K    = 17'h00400;
   localparam logic [16:0] CYC_16K   = 17'h04000;
   localparam logic [16:0] CYC_32K   = 17'h08000;
   localparam logic [16:0] CYC_64K   = 17'h10000;
   localparam logic [16:0] CYC_EXT   = 17'h00004;
   localparam logic [16:0] CYC_INT   = 17'h00004;
   localparam logic [16:0] CYC_DLV   = 17'h00002;
endpackage

/* lfoc_edge_det.sv */
// Two-stage synchroniser and rising-edge pulse for a slow oscillator clock.
`timescale 1ns/10ps
module lfoc_edge_det (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic srst_i,
   // Asynchronous oscillator clock in, one-cycle pulse out
   input  wire logic osc_i,
   output logic      rise_o
);
   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;
   logic rise_ff;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
         rise_ff  <= 1'b0;
      end else begin
         sync1_ff <= osc_i;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
         rise_ff  <= sync2_ff & ~prev_ff;
      end
   end

   assign rise_o = rise_ff;
endmodule // lfoc_edge_det

/* lfoc_osc_cnt.sv */
// Counts oscillator edges up to a target and then holds a done level.
`timescale 1ns/10ps
module lfoc_osc_cnt (
   // Clock and reset
   input  wire logic                     sys_clk_i,
   input  wire logic                     srst_i,
   // Count control
   input  wire logic                     tick_i,
   input  wire logic                     clr_i,
   input  wire logic [lfoc_pkg::CNT_W-1:0] target_i,
   output logic                          done_o
);
   logic [lfoc_pkg::CNT_W-1:0] cnt_ff;
   logic [lfoc_pkg::CNT_W-1:0] nxt_cnt;
   logic                       done_ff;

   assign nxt_cnt = cnt_ff + {{(lfoc_pkg::CNT_W-1){1'b0}}, 1'b1};

   always_ff @(posedge sys_clk_i) begin
      if (srst_i || clr_i) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else if (tick_i && !done_ff) begin
         cnt_ff  <= nxt_cnt;
         done_ff <= (nxt_cnt == target_i);
      end
   end

   assign done_o = done_ff;
endmodule // lfoc_osc_cnt

/* lfoc_ctrl.sv */
// Control of the internal 32 kHz oscillator and the 32 kHz crystal oscillator.
//
// Function
// - Internal oscillator runs only on request while its run-in-standby bit is clear.
// - Internal oscillator always runs in every mode while run-in-standby is set.
// - Internal clock goes only to a requester, four oscillator cycles after request.
// - Crystal run-in-standby acts only while the crystal enable bit is one.
// - Crystal without run-in-standby runs only on request in active and idle.
// - Crystal with run-in-standby runs in all four modes.
// - After start-up, crystal clock reaches a requester after two oscillator cycles.
// - Crystal control: standby 7, start-up 5:4, source 2, low-power 1, enable 0.
// - Start-up code selects 1k, 16k, 32k or 64k crystal cycles.
// - Source bit zero picks crystal on both pins, one picks clock on pin one.
// - Start-up and source fields ignore writes while enabled or status is one.
// - Enable lets the crystal run on request or run-in-standby and takes its pins from the port logic.
// - Crystal status is one when crystal stable or external clock running.
// - Low-power bit puts the crystal oscillator into low-power mode.
`timescale 1ns/10ps
module lfoc_ctrl (
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       srst_i,
   // Register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   // Protection unlock and sleep mode from the core
   input  wire logic       ccp_unlock_i,
   input  wire logic [1:0] sleep_mode_i,
   // Clock requests from peripherals and main clock selector
   input  wire logic       int_req_i,
   input  wire logic       xtal_req_i,
   // Raw oscillator clocks
   input  wire logic       int_osc_clk_i,
   input  wire logic       xtal_clk_i,
   // Internal oscillator control
   output logic            int_osc_en_o,
   output logic            int_avail_o,
   // Crystal oscillator control and status
   output logic            xtal_osc_en_o,
   output logic            xtal_avail_o,
   output logic            xtal_stable_o,
   output logic            xtal_low_power_o,
   output logic            xtal_ext_clk_o,
   output logic            pin_one_override_o,
   output logic            pin_two_override_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   logic       i_rsb_ff;
   logic       x_rsb_ff;
   logic [1:0] x_crystal_startup_time_ff;
   logic       x_sel_ff;
   logic       x_lp_ff;
   logic       x_en_ff;
   logic [7:0] rdata_ff;
   logic       int_en_ff;
   logic       int_avail_ff;
   logic       xtal_en_ff;
   logic       xtal_avail_ff;
   logic       pin1_ff;
   logic       pin2_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   logic                       wr_ictl;
   logic                       wr_xctl;
   logic                       cfg_lock;
   logic                       mode_awake;
   logic                       int_run;
   logic                       xtal_run;
   logic                       int_tick;
   logic                       xtal_tick;
   logic                       int_done;
   logic                       x_stable;
   logic                       dlv_done;
   logic [lfoc_pkg::CNT_W-1:0] su_target;
   logic [lfoc_pkg::CNT_W-1:0] crystal_startup_time_cycles;
   logic [7:0]                 xctl_val;
   logic [7:0]                 ictl_val;
   logic [7:0]                 stat_val;
   logic [7:0]                 rd_mux;

   assign wr_ictl    = wr_i && ccp_unlock_i && (addr_i == lfoc_pkg::ICTL_OFF);
   assign wr_xctl    = wr_i && ccp_unlock_i && (addr_i == lfoc_pkg::XCTL_OFF);
   assign cfg_lock   = x_en_ff || x_stable;
   assign mode_awake = (sleep_mode_i == lfoc_pkg::MODE_ACT) ||
                       (sleep_mode_i == lfoc_pkg::MODE_IDLE);

   // The internal oscillator obeys only its own bit and the request.
   assign int_run  = i_rsb_ff || int_req_i;
   // Run-in-standby is gated by enable; without it, requests count only when awake.
   assign xtal_run = x_en_ff && (x_rsb_ff || (xtal_req_i && mode_awake));

   assign crystal_startup_time_cycles = (x_crystal_startup_time_ff == lfoc_pkg::CRYSTAL_STARTUP_TIME_1K)  ? lfoc_pkg::CYC_1K  :
                        (x_crystal_startup_time_ff == lfoc_pkg::CRYSTAL_STARTUP_TIME_16K) ? lfoc_pkg::CYC_16K :
                        (x_crystal_startup_time_ff == lfoc_pkg::CRYSTAL_STARTUP_TIME_32K) ? lfoc_pkg::CYC_32K :
                                                            lfoc_pkg::CYC_64K;
   // An external clock needs no crystal settling, only a few seen edges.
   assign su_target = x_sel_ff ? lfoc_pkg::CYC_EXT : crystal_startup_time_cycles;

   assign xctl_val = {x_rsb_ff, 1'b0, x_crystal_startup_time_ff, 1'b0, x_sel_ff, x_lp_ff, x_en_ff};
   assign ictl_val = {i_rsb_ff, 7'h00};
   assign stat_val = {7'h00, x_stable} << lfoc_pkg::XS_BIT;
   assign rd_mux   = (addr_i == lfoc_pkg::XCTL_OFF) ? xctl_val :
                     (addr_i == lfoc_pkg::ICTL_OFF) ? ictl_val :
                     (addr_i == lfoc_pkg::STAT_OFF) ? stat_val : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Oscillator edge counting

   lfoc_edge_det u_int_edge (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .osc_i     (int_osc_clk_i),
      .rise_o    (int_tick)
   );

   lfoc_edge_det u_xtal_edge (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .osc_i     (xtal_clk_i),
      .rise_o    (xtal_tick)
   );

   // Counting starts only once the request is seen with the oscillator on.
   lfoc_osc_cnt u_int_dly (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .tick_i    (int_tick),
      .clr_i     (!(int_req_i && int_en_ff)),
      .target_i  (lfoc_pkg::CYC_INT),
      .done_o    (int_done)
   );

   // Stopping the crystal discards its settled state; the next run starts over.
   lfoc_osc_cnt u_xtal_su (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .tick_i    (xtal_tick),
      .clr_i     (!xtal_en_ff),
      .target_i  (su_target),
      .done_o    (x_stable)
   );

   // Stopping the crystal clears delivery on the same edge as its status; the registered clock output drops one cycle later.
   lfoc_osc_cnt u_xtal_dlv (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .tick_i    (xtal_tick),
      .clr_i     (!(xtal_req_i && x_stable && xtal_en_ff)),
      .target_i  (lfoc_pkg::CYC_DLV),
      .done_o    (dlv_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register file

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         i_rsb_ff <= lfoc_pkg::ICTL_RST[lfoc_pkg::RSB_BIT];
      end else if (wr_ictl) begin
         i_rsb_ff <= wdata_i[lfoc_pkg::RSB_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         x_rsb_ff <= lfoc_pkg::XCTL_RST[lfoc_pkg::RSB_BIT];
         x_lp_ff  <= lfoc_pkg::XCTL_RST[lfoc_pkg::LP_BIT];
         x_en_ff  <= lfoc_pkg::XCTL_RST[lfoc_pkg::EN_BIT];
      end else if (wr_xctl) begin
         x_rsb_ff <= wdata_i[lfoc_pkg::RSB_BIT];
         x_lp_ff  <= wdata_i[lfoc_pkg::LP_BIT];
         x_en_ff  <= wdata_i[lfoc_pkg::EN_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         x_crystal_startup_time_ff <= lfoc_pkg::XCTL_RST[lfoc_pkg::CRYSTAL_STARTUP_TIME_MSB:lfoc_pkg::CRYSTAL_STARTUP_TIME_LSB];
         x_sel_ff  <= lfoc_pkg::XCTL_RST[lfoc_pkg::SEL_BIT];
      end else if (wr_xctl && !cfg_lock) begin
         x_crystal_startup_time_ff <= wdata_i[lfoc_pkg::CRYSTAL_STARTUP_TIME_MSB:lfoc_pkg::CRYSTAL_STARTUP_TIME_LSB];
         x_sel_ff  <= wdata_i[lfoc_pkg::SEL_BIT];
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= rd_i ? rd_mux : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Oscillator and pin control outputs

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         int_en_ff     <= 1'b0;
         int_avail_ff  <= 1'b0;
         xtal_en_ff    <= 1'b0;
         xtal_avail_ff <= 1'b0;
         pin1_ff       <= 1'b0;
         pin2_ff       <= 1'b0;
      end else begin
         int_en_ff     <= int_run;
         int_avail_ff  <= int_done && int_req_i;
         xtal_en_ff    <= xtal_run;
         xtal_avail_ff <= dlv_done && xtal_req_i;
         pin1_ff       <= x_en_ff;
         pin2_ff       <= x_en_ff && !x_sel_ff;
      end
   end

   assign rdata_o            = rdata_ff;
   assign int_osc_en_o       = int_en_ff;
   assign int_avail_o        = int_avail_ff;
   assign xtal_osc_en_o      = xtal_en_ff;
   assign xtal_avail_o       = xtal_avail_ff;
   assign xtal_stable_o      = x_stable;
   assign xtal_low_power_o   = x_lp_ff;
   assign xtal_ext_clk_o     = x_sel_ff;
   assign pin_one_override_o = pin1_ff;
   assign pin_two_override_o = pin2_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_unlocked_xctl_write;
      wr_xctl && cfg_lock;
   endsequence

   sequence s_fields_hold;
      $stable(x_crystal_startup_time_ff) && $stable(x_sel_ff);
   endsequence

   chk_int_always_run: assert property (i_rsb_ff |=> int_osc_en_o)
      else $error("internal oscillator stopped while run-in-standby set");

   chk_int_idle_stop: assert property (!i_rsb_ff && !int_req_i |=> !int_osc_en_o)
      else $error("internal oscillator running without request");

   chk_int_avail_req: assert property (int_avail_o |-> $past(int_req_i) && int_osc_en_o)
      else $error("internal clock delivered without request");

   chk_int_avail_late: assert property ($rose(int_req_i) |-> !int_avail_o [*4])
      else $error("internal clock delivered too early");

   chk_xtal_en_gate: assert property (!x_en_ff |=> !xtal_osc_en_o)
      else $error("crystal running while disabled");

   chk_xtal_sleep_stop: assert property (x_en_ff && !x_rsb_ff && !mode_awake |=> !xtal_osc_en_o)
      else $error("crystal running in deep sleep without run-in-standby");

   chk_xtal_rsb_run: assert property (x_en_ff && x_rsb_ff |=> xtal_osc_en_o)
      else $error("crystal stopped while run-in-standby set");

   chk_xtal_dlv_stable: assert property (xtal_avail_o |-> $past(x_stable) && $past(xtal_req_i))
      else $error("crystal clock delivered before start-up ended");

   chk_lock_fields: assert property (s_unlocked_xctl_write |=> s_fields_hold)
      else $error("locked start-up or source field changed");

   chk_unprot_write: assert property (!wr_xctl |=> $stable(x_en_ff) && $stable(x_rsb_ff))
      else $error("crystal control changed without unlock");

   chk_pin_take: assert property (x_en_ff ##1 x_en_ff |-> pin_one_override_o)
      else $error("crystal pins not taken while enabled");

   chk_stat_read: assert property (rd_i && addr_i == lfoc_pkg::STAT_OFF
                                   |=> rdata_o[lfoc_pkg::XS_BIT] == $past(x_stable))
      else $error("status read does not show crystal status");

   chk_pin_two_ext: assert property (x_en_ff && x_sel_ff |=> !pin_two_override_o)
      else $error("pin two taken while external clock selected");

   chk_lp_write: assert property (wr_xctl
                                 |=> xtal_low_power_o == $past(wdata_i[lfoc_pkg::LP_BIT]))
      else $error("low-power setting does not follow the write");

   chk_stat_stop: assert property (!xtal_en_ff |=> !xtal_stable_o)
      else $error("crystal status kept while crystal stopped");

   chk_ictl_hold: assert property (!wr_ictl |=> $stable(i_rsb_ff))
      else $error("internal oscillator control changed without unlock");

   chk_xtal_avail_drop: assert property (!xtal_req_i |=> !xtal_avail_o)
      else $error("crystal clock delivered without request");

endmodule // lfoc_ctrl

/* test_low_freq_osc_control.sv */
// Self-checking bench for the low-frequency oscillator control block.
`timescale 1ns/10ps
module test_low_freq_osc_control;
   logic       sys_clk_i, srst_i, wr_i, rd_i, ccp_unlock_i;
   logic       int_req_i, xtal_req_i, int_osc_clk_i, xtal_clk_i;
   logic [7:0] addr_i, wdata_i, rdata_o;
   logic [1:0] sleep_mode_i;
   logic       int_osc_en_o, int_avail_o, xtal_osc_en_o, xtal_avail_o;
   logic       xtal_stable_o, xtal_low_power_o, xtal_ext_clk_o;
   logic       pin_one_override_o, pin_two_override_o;
   logic [7:0] exp_q[$];
   logic       rd_d = 1'b0;
   int         mismatches = 0;
   int         check_count = 0;

   lfoc_ctrl dut (
      .sys_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .ccp_unlock_i, .sleep_mode_i, .int_req_i, .xtal_req_i,
      .int_osc_clk_i, .xtal_clk_i, .int_osc_en_o, .int_avail_o,
      .xtal_osc_en_o, .xtal_avail_o, .xtal_stable_o, .xtal_low_power_o,
      .xtal_ext_clk_o, .pin_one_override_o, .pin_two_override_o
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic b(input logic seen, input logic exp);
      chk({7'h0, seen}, {7'h0, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      ccp_unlock_i <= u;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      ccp_unlock_i <= 1'b0;
   endtask

   // The expected read value is noted first; the monitor below pops it.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
   endtask

   // Oscillator edges are kept slow against the system clock so that the
   // internal synchroniser never misses one.
   task automatic osc(input bit x, input int n);
      repeat (n) begin
         if (x) xtal_clk_i <= 1'b1;
         else int_osc_clk_i <= 1'b1;
         cyc(2);
         if (x) xtal_clk_i <= 1'b0;
         else int_osc_clk_i <= 1'b0;
         cyc(2);
      end
   endtask

   // Bit m of exp is whether the crystal should run in sleep mode m.
   task automatic modes(input logic [3:0] exp);
      for (int m = 0; m < 4; m++) begin
         sleep_mode_i <= m[1:0];
         cyc(4);
         b(xtal_osc_en_o, exp[m]);
      end
      sleep_mode_i <= 2'h0;
   endtask

   task automatic wait_int();
      int i;
      for (i = 0; i < 40 && int_avail_o !== 1'b1; i++) cyc(1);
      if (i == 40) begin
         mismatches++;
         give_verdict();
      end
   endtask

   task automatic done(input int n);
      $display("test %0d done", n);
   endtask

   always @(posedge sys_clk_i) begin
      if (rd_d) chk(rdata_o, exp_q.pop_front());
      rd_d <= rd_i;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      srst_i = 1'b1;
      {wr_i, rd_i, ccp_unlock_i, int_req_i, xtal_req_i} = '0;
      {int_osc_clk_i, xtal_clk_i, addr_i, wdata_i, sleep_mode_i} = '0;
      void'($urandom(32'h5F69F293));
      cyc(8);
      srst_i <= 1'b0;
      rd(8'h1C, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h40 | 8'($urandom % 64), 8'h00);
      wr(8'h1C, 8'($urandom), 1'b0);
      wr(8'h18, 8'h80, 1'b0);
      rd(8'h1C, 8'h00);
      rd(8'h18, 8'h00);
      done(1);
      wr(8'h1C, 8'hFE, 1'b1);
      rd(8'h1C, 8'hB6);
      cyc(3);
      b(xtal_low_power_o, 1'b1);
      b(xtal_ext_clk_o, 1'b1);
      b(pin_one_override_o, 1'b0);
      modes(4'h0);
      done(2);
      wr(8'h1C, 8'h04, 1'b1);
      wr(8'h1C, 8'h05, 1'b1);
      cyc(3);
      b(pin_one_override_o, 1'b1);
      b(pin_two_override_o, 1'b0);
      wr(8'h1C, 8'h31, 1'b1);
      rd(8'h1C, 8'h05);
      xtal_req_i <= 1'b1;
      modes(4'h3);
      osc(1'b1, 4);
      cyc(8);
      b(xtal_stable_o, 1'b1);
      rd(8'h04, 8'h10);
      osc(1'b1, 3);
      cyc(6);
      b(xtal_avail_o, 1'b1);
      wr(8'h1C, 8'h85, 1'b1);
      xtal_req_i <= 1'b0;
      modes(4'hF);
      wr(8'h1C, 8'h84, 1'b1);
      modes(4'h0);
      done(3);
      cyc(4);
      wr(8'h1C, 8'h00, 1'b1);
      wr(8'h1C, 8'h01, 1'b1);
      xtal_req_i <= 1'b1;
      cyc(3);
      b(pin_two_override_o, 1'b1);
      osc(1'b1, 1000);
      cyc(8);
      b(xtal_stable_o, 1'b0);
      osc(1'b1, 40);
      cyc(8);
      b(xtal_stable_o, 1'b1);
      wr(8'h1C, 8'h00, 1'b1);
      cyc(4);
      wr(8'h1C, 8'h10, 1'b1);
      wr(8'h1C, 8'h11, 1'b1);
      rd(8'h1C, 8'h11);
      osc(1'b1, 1100);
      cyc(8);
      b(xtal_stable_o, 1'b0);
      xtal_req_i <= 1'b0;
      done(4);
      cyc(3);
      b(int_osc_en_o, 1'b0);
      int_req_i <= 1'b1;
      cyc(3);
      b(int_osc_en_o, 1'b1);
      osc(1'b0, 3);
      cyc(8);
      b(int_avail_o, 1'b0);
      osc(1'b0, 1);
      wait_int();
      b(int_avail_o, 1'b1);
      int_req_i <= 1'b0;
      cyc(4);
      b(int_osc_en_o, 1'b0);
      b(int_avail_o, 1'b0);
      wr(8'h18, 8'hFF, 1'b1);
      rd(8'h18, 8'h80);
      sleep_mode_i <= 2'h3;
      cyc(4);
      b(int_osc_en_o, 1'b1);
      b(int_avail_o, 1'b0);
      done(5);
      cyc(4);
      give_verdict();
   end
endmodule // test_low_freq_osc_control
